//--- logic/seps_supply_seq.sv
`timescale 1ns/100ps
`default_nettype none
module seps_supply_seq
    import seps_pkg::*;
#(
    parameter int unsigned MS_CYC       = MS_TICK_CYC,
    parameter int unsigned HOT_LONG_CYC_P = HOT_LONG_CYC
) (
    input  wire logic          sys_clk,          // Sequencer clock.
    input  wire logic          rstn,             // Synchronous reset, low.
    input  wire seps_reg_req_s regReq,           // Register access request.
    output logic [7:0]         regRdData,        // Read data, registered.
    output logic               regAck,           // Access acknowledge.
    input  wire seps_pins_s    pins,             // Trigger and enable pins.
    input  wire logic          hotResetReqN,     // Hot reset pin, low.
    input  wire logic          wakeRequest,      // Wake from sleep.
    input  wire logic          powerUpStart,     // Leave the RTC state.
    input  wire logic          sysLowInput,      // Low system input voltage.
    input  wire logic [2:0]    railInReg,        // Regulation sense BA,BB,L4.
    input  wire logic          crystalClockIn,   // Crystal 32 kHz clock.
    input  wire logic          slowClockLogicSupply, // Slow clock supply ok.
    output logic [12:0]        railOn,           // Rail enables to regulators.
    output seps_pg_s           powerGood,        // Power-good outputs.
    output logic               noPowerResetOut,  // Host reset, low active.
    output logic               noRtcOut,         // RTC reset, low active.
    output logic               slowClockOut,     // 32 kHz output.
    output logic               rtcSourceInternal, // Internal oscillator sel.
    output logic [7:0]         linregZeroVoltage, // Non-ramped rail code.
    output logic [7:0]         buckAVoltage      // Ramped rail code.
);
    seps_state_e state;
    logic [7:0]  supplyEnableFirst;
    logic [7:0]  supplyEnableSecond;
    logic [7:0]  linearEnableFirst;
    logic [7:0]  linearEnableSecond;
    logic [7:0]  stateAndMiscControl;
    logic [7:0]  rtcControl;
    logic [7:0]  buckAInit;
    logic [7:0]  buckAFinal;
    logic        rampGo;
    logic [12:0] ramOn;
    logic [12:0] trigActive;
    logic [12:0] keepMask;
    logic [12:0] pinNormal;
    logic        inRequest;
    logic        timerRun;
    logic        msTick;
    logic        rampTick;
    logic [3:0]  reqTicks;
    logic        reqDone;
    logic        linregFourHold;
    logic [17:0] hotCnt;
    logic [17:0] hotLimit;
    logic        hotEvent;
    logic        hotSeen;
    logic        wrHit;
    logic        enterReq;
    logic        enterOff;
    logic [2:0]  pgRaw;

    assign wrHit = regReq.wr;
    assign inRequest = (state == ST_SLEEP_REQ) || (state == ST_REBOOT_REQ);
    assign timerRun = inRequest || (state == ST_HARD_REBOOT);

    // Millisecond tick for the request wait and hard-reboot hold.
    seps_tick_div #(.DIV(MS_CYC)) u_ms_tick (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .run     (timerRun),
        .tick    (msTick)
    );

    // Step tick for the buck_a voltage ramp.
    seps_tick_div #(.DIV(RAMP_STEP_CYC)) u_ramp_tick (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .run     (rampGo),
        .tick    (rampTick)
    );

    // Each rail is on when any of its enable bits is set.
    always_comb begin
        ramOn = '0;
        ramOn[0]  = linearEnableFirst[0] | linearEnableSecond[0];
        ramOn[1]  = linearEnableFirst[1] | linearEnableSecond[1];
        ramOn[2]  = |supplyEnableFirst[3:2] | |supplyEnableSecond[3:2];
        ramOn[3]  = linearEnableFirst[2] | linearEnableSecond[2];
        ramOn[4]  = linearEnableFirst[3] | linearEnableSecond[3];
        ramOn[5]  = stateAndMiscControl[MISC_LINREG5_ON];
        ramOn[6]  = linearEnableFirst[4] | linearEnableSecond[4];
        ramOn[7]  = linearEnableFirst[5] | linearEnableSecond[5];
        ramOn[8]  = linearEnableFirst[6] | linearEnableSecond[6];
        ramOn[9]  = stateAndMiscControl[MISC_LINREG9_ON];
        ramOn[10] = supplyEnableFirst[1] | supplyEnableSecond[1];
        ramOn[11] = supplyEnableFirst[0] | supplyEnableSecond[0];
        ramOn[12] = linearEnableFirst[7] | linearEnableSecond[7];
    end

    // Trigger level per rail: buck_a group acts on a low pin, buck_b and sync groups on a high pin, internal group outside off states.
    assign trigActive = (TRIG_INT_MASK & {NRAIL{!enterOff}})
                      | (TRIG_BA_MASK & {NRAIL{!pins.buckAEnablePin}})
                      | (TRIG_BB_MASK & {NRAIL{pins.buckBEnablePin}})
                      | (TRIG_SYNC_MASK & {NRAIL{pins.syncEnablePin}});

    // Rails that may stay on during a request state.
    always_comb begin
        keepMask = trigActive;
        keepMask = keepMask | TRIG_INT_MASK;
        keepMask[RAIL_L4] = linregFourHold || pins.linregFourEnablePin;
    end

    // Pins that steer their own rail while in normal state.
    always_comb begin
        pinNormal = '0;
        pinNormal[RAIL_BA] = !pins.buckAEnablePin;
        pinNormal[RAIL_BB] = pins.buckBEnablePin;
        pinNormal[RAIL_L4] = pins.linregFourEnablePin;
    end

    // Hot reset deglitch: the pin must stay low for the selected time.
    assign hotLimit = stateAndMiscControl[MISC_HOT_DLY]
                    ? 18'(HOT_LONG_CYC_P - 1)
                    : 18'(HOT_SHORT_CYC - 1);
    assign hotEvent = !hotResetReqN && !hotSeen && (hotCnt == hotLimit);

    always_ff @(posedge sys_clk) begin
        if (!rstn || hotResetReqN) begin
            hotCnt  <= '0;
            hotSeen <= 1'b0;
        end else if (hotEvent) begin
            hotSeen <= 1'b1;
        end else if (!hotSeen) begin
            hotCnt <= hotCnt + 1'b1;
        end
    end

    // Request-state millisecond count.
    assign reqDone = msTick && (reqTicks == 4'(REQ_WAIT_MS - 1));

    always_ff @(posedge sys_clk) begin
        if (!rstn || !timerRun) begin
            reqTicks <= '0;
        end else if (msTick) begin
            reqTicks <= reqTicks + 1'b1;
        end
    end

    // Next-state requests taken from control bits and pins.
    assign enterReq = (state == ST_NORMAL)
                   && (stateAndMiscControl[MISC_SLEEP]
                       || stateAndMiscControl[MISC_REBOOT]
                       || hotEvent
                       || (sysLowInput
                           && stateAndMiscControl[MISC_LOWIN_SLEEP]));
    assign enterOff = (state == ST_SLEEP) || (state == ST_HARD_REBOOT)
                   || (state == ST_RTC);

    // Sequencer state machine.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state <= ST_RTC;
        end else begin
            case (state)
                ST_RTC: begin
                    if (powerUpStart) begin
                        state <= ST_SEQ;
                    end
                end
                ST_SEQ: begin
                    if (stateAndMiscControl[MISC_NORMAL]) begin
                        state <= ST_NORMAL;
                    end
                end
                ST_NORMAL: begin
                    if (enterReq) begin
                        if (stateAndMiscControl[MISC_REBOOT] || hotEvent) begin
                            state <= ST_REBOOT_REQ;
                        end else begin
                            state <= ST_SLEEP_REQ;
                        end
                    end
                end
                ST_SLEEP_REQ: begin
                    if (stateAndMiscControl[MISC_EXIT_SLREQ]) begin
                        state <= ST_NORMAL;
                    end else if (reqDone) begin
                        state <= ST_SLEEP;
                    end
                end
                ST_REBOOT_REQ: begin
                    if (reqDone) begin
                        state <= ST_HARD_REBOOT;
                    end
                end
                ST_SLEEP: begin
                    if (wakeRequest) begin
                        state <= ST_SEQ;
                    end
                end
                ST_HARD_REBOOT: begin
                    if (msTick) begin
                        state <= ST_SEQ;
                    end
                end
                default: begin
                    state <= ST_RTC;
                end
            endcase
        end
    end

    // Regulator four hold flag caught on request entry.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            linregFourHold <= 1'b0;
        end else if (enterReq) begin
            linregFourHold <= !pins.linregFourEnablePin;
        end
    end

    // Rail enables by state.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            railOn <= '0;
        end else begin
            case (state)
                ST_SEQ: begin
                    railOn <= (DEFAULT_ON_MASK & trigActive)
                            | (ramOn & SEQ_RAM_MASK);
                end
                ST_NORMAL: begin
                    railOn <= ramOn | pinNormal;
                end
                ST_SLEEP_REQ, ST_REBOOT_REQ: begin
                    if (reqDone) begin
                        railOn <= '0;
                    end else begin
                        railOn <= railOn & keepMask;
                    end
                end
                default: begin
                    railOn <= '0;
                end
            endcase
        end
    end

    // Power-good: on and in regulation; regulator four also needs its pin.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pgRaw <= '0;
        end else begin
            pgRaw <= {railOn[RAIL_BA], railOn[RAIL_BB], railOn[RAIL_L4]}
                   & railInReg;
        end
    end

    assign powerGood.buckAPowerGood      = pgRaw[2];
    assign powerGood.buckBPowerGood      = pgRaw[1];
    assign powerGood.linregFourPowerGood = pgRaw[0]
                                         && pins.linregFourEnablePin;

    // Host reset outputs and the slow clock.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            noPowerResetOut <= 1'b0;
            noRtcOut        <= 1'b0;
            slowClockOut    <= 1'b0;
        end else begin
            noPowerResetOut <= (state == ST_SEQ) || (state == ST_NORMAL)
                            || (state == ST_SLEEP_REQ);
            noRtcOut        <= 1'b1;
            slowClockOut    <= crystalClockIn && noRtcOut
                            && slowClockLogicSupply;
        end
    end

    assign rtcSourceInternal = rtcControl[RTC_SRC_SEL];

    // Enable and RTC control registers; reserved enable bits never store.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            supplyEnableFirst  <= RST_SUPPLY_EN_FIRST;
            supplyEnableSecond <= RST_SUPPLY_EN_SECOND;
            linearEnableFirst  <= RST_LINEAR_EN_FIRST;
            linearEnableSecond <= RST_LINEAR_EN_SECOND;
            rtcControl         <= RST_RTC_CTRL;
        end else if (wrHit) begin
            case (regReq.addr)
                ADDR_SUPPLY_EN_FIRST: begin
                    supplyEnableFirst <= regReq.wdata & SUPPLY_EN_MASK;
                end
                ADDR_SUPPLY_EN_SECOND: begin
                    supplyEnableSecond <= regReq.wdata & SUPPLY_EN_MASK;
                end
                ADDR_LINEAR_EN_FIRST: begin
                    linearEnableFirst <= regReq.wdata;
                end
                ADDR_LINEAR_EN_SECOND: begin
                    linearEnableSecond <= regReq.wdata;
                end
                ADDR_RTC_CTRL: begin
                    rtcControl <= regReq.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // State control register; a software write wins over hardware clears.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            stateAndMiscControl <= RST_STATE_MISC;
        end else if (wrHit && (regReq.addr == ADDR_STATE_MISC)) begin
            stateAndMiscControl <= regReq.wdata;
        end else if (enterReq) begin
            stateAndMiscControl[MISC_SLEEP]  <= 1'b0;
            stateAndMiscControl[MISC_REBOOT] <= 1'b0;
        end else if (enterOff) begin
            stateAndMiscControl[MISC_NORMAL] <= 1'b0;
        end
    end

    // Voltage codes: direct for the non-ramped rail, ramped for buck_a.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            linregZeroVoltage <= RST_VOLT;
            buckAInit         <= RST_VOLT;
            buckAFinal        <= RST_VOLT;
            buckAVoltage      <= RST_VOLT;
            rampGo            <= 1'b0;
        end else begin
            if (wrHit && (regReq.addr == ADDR_LINREG0_VOLT)) begin
                linregZeroVoltage <= regReq.wdata;
            end
            if (wrHit && (regReq.addr == ADDR_BUCKA_VINIT)) begin
                buckAInit <= regReq.wdata;
            end
            if (wrHit && (regReq.addr == ADDR_BUCKA_VFINAL)) begin
                buckAFinal <= regReq.wdata;
            end
            if (wrHit && (regReq.addr == ADDR_BUCKA_RAMP)) begin
                rampGo <= regReq.wdata[0];
            end else if (rampGo && (buckAVoltage == buckAFinal)) begin
                rampGo <= 1'b0;
            end
            if (!rampGo && wrHit && (regReq.addr == ADDR_BUCKA_VINIT)) begin
                buckAVoltage <= regReq.wdata;
            end else if (rampTick && (buckAVoltage < buckAFinal)) begin
                buckAVoltage <= buckAVoltage + 1'b1;
            end else if (rampTick && (buckAVoltage > buckAFinal)) begin
                buckAVoltage <= buckAVoltage - 1'b1;
            end
        end
    end

    // Read port and acknowledge; unmapped addresses read zero.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            regRdData <= '0;
            regAck    <= 1'b0;
        end else begin
            regAck <= regReq.wr || regReq.rd;
            if (regReq.rd) begin
                case (regReq.addr)
                    ADDR_SUPPLY_EN_FIRST:  regRdData <= supplyEnableFirst;
                    ADDR_SUPPLY_EN_SECOND: regRdData <= supplyEnableSecond;
                    ADDR_LINEAR_EN_FIRST:  regRdData <= linearEnableFirst;
                    ADDR_LINEAR_EN_SECOND: regRdData <= linearEnableSecond;
                    ADDR_STATE_MISC:       regRdData <= stateAndMiscControl;
                    ADDR_LINREG0_VOLT:     regRdData <= linregZeroVoltage;
                    ADDR_BUCKA_VINIT:      regRdData <= buckAInit;
                    ADDR_BUCKA_VFINAL:     regRdData <= buckAFinal;
                    ADDR_BUCKA_RAMP:       regRdData <= {7'h00, rampGo};
                    ADDR_RAIL_STAT_LO:     regRdData <= railOn[7:0];
                    ADDR_RAIL_STAT_HI:     regRdData <= {state, railOn[12:8]};
                    ADDR_RTC_CTRL:         regRdData <= rtcControl;
                    default:               regRdData <= 8'h00;
                endcase
            end
        end
    end
endmodule : seps_supply_seq
`default_nettype wire

//--- shared/seps_pkg.sv
`default_nettype none
package seps_pkg;
    // Sequencer clock and derived timing.
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned MS_PER_S        = 1_000;
    localparam int unsigned US_PER_S        = 1_000_000;
    localparam int unsigned REQ_WAIT_MS     = 10;
    localparam int unsigned MS_TICK_CYC     = CLK_HZ / MS_PER_S;
    localparam int unsigned HOT_SHORT_US    = 10;
    localparam int unsigned HOT_SHORT_CYC   = HOT_SHORT_US * CLK_HZ / US_PER_S;
    localparam int unsigned HOT_LONG_MS     = 5;
    localparam int unsigned HOT_LONG_CYC    = HOT_LONG_MS * CLK_HZ / MS_PER_S;
    localparam int unsigned RAMP_STEP_US    = 10;
    localparam int unsigned RAMP_STEP_CYC   = RAMP_STEP_US * CLK_HZ / US_PER_S;

    // Register offsets.
    localparam logic [7:0] ADDR_SUPPLY_EN_FIRST  = 8'h10;
    localparam logic [7:0] ADDR_SUPPLY_EN_SECOND = 8'h11;
    localparam logic [7:0] ADDR_LINEAR_EN_FIRST  = 8'h12;
    localparam logic [7:0] ADDR_LINEAR_EN_SECOND = 8'h13;
    localparam logic [7:0] ADDR_STATE_MISC       = 8'h14;
    localparam logic [7:0] ADDR_LINREG0_VOLT     = 8'h30;
    localparam logic [7:0] ADDR_BUCKA_VINIT      = 8'h31;
    localparam logic [7:0] ADDR_BUCKA_VFINAL     = 8'h32;
    localparam logic [7:0] ADDR_BUCKA_RAMP       = 8'h33;
    localparam logic [7:0] ADDR_RAIL_STAT_LO     = 8'h34;
    localparam logic [7:0] ADDR_RAIL_STAT_HI     = 8'h35;
    localparam logic [7:0] ADDR_RTC_CTRL         = 8'hc0;

    // Reset values and writable-bit masks.
    localparam logic [7:0] RST_SUPPLY_EN_FIRST  = 8'h0f;
    localparam logic [7:0] RST_SUPPLY_EN_SECOND = 8'h00;
    localparam logic [7:0] RST_LINEAR_EN_FIRST  = 8'h12;
    localparam logic [7:0] RST_LINEAR_EN_SECOND = 8'h00;
    localparam logic [7:0] RST_STATE_MISC       = 8'h40;
    localparam logic [7:0] RST_VOLT             = 8'h00;
    localparam logic [7:0] RST_RTC_CTRL         = 8'h00;
    localparam logic [7:0] SUPPLY_EN_MASK       = 8'h0f;

    // Fields of the state and misc control register and the RTC control register.
    localparam int unsigned MISC_LINREG9_ON  = 7;
    localparam int unsigned MISC_LINREG5_ON  = 6;
    localparam int unsigned MISC_LOWIN_SLEEP = 5;
    localparam int unsigned MISC_HOT_DLY     = 4;
    localparam int unsigned MISC_SLEEP       = 3;
    localparam int unsigned MISC_NORMAL      = 2;
    localparam int unsigned MISC_EXIT_SLREQ  = 1;
    localparam int unsigned MISC_REBOOT      = 0;
    localparam int unsigned RTC_SRC_SEL      = 6;

    // Rails: 2 third buck, 10 buck_a, 11 buck_b, all others (0,1,3..9,12) linear regulators.
    localparam int unsigned NRAIL   = 13;
    localparam int unsigned RAIL_L4 = 4;
    localparam int unsigned RAIL_BA = 10;
    localparam int unsigned RAIL_BB = 11;
    localparam logic [12:0] DEFAULT_ON_MASK = 13'h0c66;
    localparam logic [12:0] TRIG_INT_MASK   = 13'h1094;
    localparam logic [12:0] TRIG_BA_MASK    = 13'h0400;
    localparam logic [12:0] TRIG_BB_MASK    = 13'h0809;
    localparam logic [12:0] TRIG_SYNC_MASK  = 13'h0362;
    localparam logic [12:0] SEQ_RAM_MASK    = 13'h0c14;

    typedef enum logic [2:0] {
        ST_RTC, ST_SEQ, ST_NORMAL, ST_SLEEP_REQ,
        ST_REBOOT_REQ, ST_SLEEP, ST_HARD_REBOOT
    } seps_state_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } seps_reg_req_s;

    typedef struct packed {
        logic buckAEnablePin;
        logic buckBEnablePin;
        logic linregFourEnablePin;
        logic syncEnablePin;
    } seps_pins_s;

    typedef struct packed {
        logic buckAPowerGood;
        logic buckBPowerGood;
        logic linregFourPowerGood;
    } seps_pg_s;
endpackage : seps_pkg
`default_nettype wire

//--- logic/seps_tick_div.sv
`timescale 1ns/100ps
`default_nettype none
module seps_tick_div #(
    parameter int unsigned DIV = 2
) (
    input  wire logic sys_clk,  // Sequencer clock.
    input  wire logic rstn,     // Synchronous reset, active low.
    input  wire logic run,      // Count while high, restart when low.
    output logic      tick      // One-cycle pulse every DIV cycles.
);
    localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt;

    // Free count that restarts whenever the enable drops.
    always_ff @(posedge sys_clk) begin
        if (!rstn || !run) begin
            cnt <= '0;
        end else if (cnt == LAST) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    // The pulse marks the last cycle of each period.
    assign tick = run && (cnt == LAST);
endmodule : seps_tick_div
`default_nettype wire

//--- tb/seps_chk_properties.sv
`timescale 1ns/100ps
`default_nettype none
module seps_chk
    import seps_pkg::*;
(
    input wire logic          sys_clk,       // Clock.
    input wire logic          rstn,          // Reset, low.
    input wire seps_reg_req_s regReq,        // Register request.
    input wire logic [7:0]    regRdData,     // Read data.
    input wire logic          regAck,        // Acknowledge.
    input wire seps_pins_s    pins,          // Host pins.
    input wire logic [2:0]    railInReg,     // Regulation sense.
    input wire logic [12:0]   railOn,        // Rail enables.
    input wire seps_pg_s      powerGood,     // Power-good outputs.
    input wire logic          noRtcOut,      // RTC reset.
    input wire logic          slowClockOut,  // Slow clock.
    input wire logic          crystalClockIn, // Crystal clock.
    input wire logic          slowClockLogicSupply, // Supply valid.
    input wire logic [7:0]    linregZeroVoltage // Voltage code.
);
    // All checks share the sequencer clock and its reset.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    AST_ACK: assert property (regReq.wr || regReq.rd |=> regAck)
        else $error("missing acknowledge");
    AST_ACK_CAUSE: assert property (regAck |-> $past(regReq.wr || regReq.rd))
        else $error("acknowledge without access");
    AST_RSVD: assert property (regReq.rd &&
        regReq.addr == ADDR_SUPPLY_EN_FIRST |=> regRdData[7:4] == 4'h0)
        else $error("reserved enable bits not zero");
    AST_VOLT: assert property (regReq.wr &&
        regReq.addr == ADDR_LINREG0_VOLT |=>
        linregZeroVoltage == $past(regReq.wdata))
        else $error("voltage not applied on acknowledge");
    AST_L4PG: assert property (!pins.linregFourEnablePin |->
        !powerGood.linregFourPowerGood)
        else $error("regulator four power good high with pin low");
    AST_PG_A: assert property (powerGood.buckAPowerGood |->
        $past(railOn[RAIL_BA] && railInReg[2]))
        else $error("buck a power good without rail");
    AST_PG_B: assert property ($past(!railOn[RAIL_BB]) |->
        !powerGood.buckBPowerGood)
        else $error("buck b power good while off");
    AST_CLK: assert property (slowClockOut == $past(crystalClockIn &&
        noRtcOut && slowClockLogicSupply))
        else $error("slow clock output wrong");
    AST_NO_RTC_RESET_OUT: assert property ($past(rstn) |-> noRtcOut)
        else $error("rtc reset output low after reset");
endmodule : seps_chk
`default_nettype wire

//--- tb/seps_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module seps_host_model
    import seps_pkg::*;
(
    input  wire logic        sys_clk,  // Clock.
    input  wire seps_pins_s  setPins,  // Levels the bench asks for.
    input  wire logic [12:0] railOn,   // Rail enables.
    output seps_pins_s       pins,     // Pin levels to the device.
    output logic [2:0]       railInReg // Regulation sense.
);
    // Pins move just after the edge; inputs powered first, so rails settle.
    always @(posedge sys_clk) begin
        pins <= #1 setPins;
        railInReg <= #1 {railOn[RAIL_BA], railOn[RAIL_BB], railOn[RAIL_L4]};
    end
endmodule : seps_host_model
`default_nettype wire

//--- tb/supply_enable_powerdown_seq_test.sv
`timescale 1ns/100ps
`default_nettype none
module supply_enable_powerdown_seq_test
    import seps_pkg::*;
;
    logic sys_clk = 0, rstn = 0, powerUpStart = 0, crystalClockIn = 0;
    logic regAck, noPowerResetOut, noRtcOut, slowClockOut;
    logic hotResetReqN = 1, slowClockLogicSupply = 1, rtcSourceInternal;
    logic [7:0] regRdData, rd, linregZeroVoltage, buckAVoltage;
    logic [12:0] railOn;
    logic [2:0] railInReg;
    logic [7:0] resetVals [5] = '{8'h0f, 8'h00, 8'h12, 8'h00, 8'h40};
    seps_reg_req_s regReq = '0;
    seps_pins_s setPins = 4'b0111, pins;
    seps_pg_s powerGood;
    int errorCnt = 0, totalChecks = 0, cycles = 0;
    seps_host_model host_u (.sys_clk, .setPins, .railOn, .pins, .railInReg);
    seps_supply_seq #(.MS_CYC(20), .HOT_LONG_CYC_P(30)) dut_u (.sys_clk,
        .rstn, .regReq, .regRdData, .regAck, .pins, .hotResetReqN,
        .wakeRequest(1'b0), .powerUpStart, .sysLowInput(1'b0), .railInReg,
        .crystalClockIn, .slowClockLogicSupply, .railOn, .powerGood,
        .noPowerResetOut, .noRtcOut, .slowClockOut, .rtcSourceInternal,
        .linregZeroVoltage, .buckAVoltage);
    // Clock, crystal stand-in and a hang limit.
    always #10 sys_clk = ~sys_clk;
    always #100 crystalClockIn = ~crystalClockIn;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            errorCnt++;
            results();
        end
    end
    task automatic results();
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    task automatic check(input string what, input logic [15:0] seen, exp);
        totalChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic waitCycles(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : waitCycles
    // One register cycle; acknowledge and data arrive one edge later.
    task automatic access(input logic w, input logic [7:0] a, d);
        @(posedge sys_clk) #1;
        regReq = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk) #1;
        regReq = '0;
        rd = regRdData;
        check("ack", regAck, 1);
    endtask : access
    // Main sequence: registers, power-up, normal control, sleep power-down.
    initial begin
        waitCycles(8);
        rstn = 1;
        for (int i = 0; i < 5; i++) begin
            access(0, 8'(ADDR_SUPPLY_EN_FIRST + i), 0);
            check("reset value", rd, resetVals[i]);
        end
        access(1, ADDR_SUPPLY_EN_FIRST, 8'hff);
        access(0, ADDR_SUPPLY_EN_FIRST, 0);
        check("reserved bits", rd, 8'h0f);
        access(0, 8'h7e, 0);
        check("unmapped", rd, 8'h00);
        access(1, ADDR_LINREG0_VOLT, 8'h55);
        check("voltage", linregZeroVoltage, 8'h55);
        access(1, ADDR_RTC_CTRL, 8'h40);
        check("source select", rtcSourceInternal, 1);
        slowClockLogicSupply = 0;
        @(posedge crystalClockIn) waitCycles(2);
        check("slow clock gated", slowClockOut, 0);
        slowClockLogicSupply = 1;
        @(posedge crystalClockIn) waitCycles(2);
        check("slow clock on", slowClockOut, 1);
        access(1, ADDR_BUCKA_VINIT, 8'h20);
        access(1, ADDR_BUCKA_VFINAL, 8'h21);
        check("ramp start", buckAVoltage, 8'h20);
        access(1, ADDR_BUCKA_RAMP, 8'h01);
        waitCycles(502);
        check("ramp end", buckAVoltage, 8'h21);
        powerUpStart = 1;
        waitCycles(4);
        check("default off rail", railOn[0], 0);
        access(1, ADDR_STATE_MISC, 8'h44);
        access(0, ADDR_RAIL_STAT_HI, 0);
        check("state normal", rd[7:5], 3'd2);
        hotResetReqN = 0;
        waitCycles(200);
        hotResetReqN = 1;
        access(0, ADDR_RAIL_STAT_HI, 0);
        check("short hot reset", rd[7:5], 3'd2);
        setPins.buckAEnablePin = 1;
        access(1, ADDR_SUPPLY_EN_FIRST, 8'h0d);
        waitCycles(3);
        check("buck a off", railOn[RAIL_BA], 0);
        access(1, ADDR_SUPPLY_EN_SECOND, 8'h02);
        waitCycles(2);
        check("buck a on", railOn[RAIL_BA], 1);
        setPins.linregFourEnablePin = 0;
        access(1, ADDR_LINEAR_EN_FIRST, 8'h1a);
        waitCycles(2);
        check("reg four on", railOn[RAIL_L4], 1);
        check("reg four good", powerGood.linregFourPowerGood, 0);
        access(1, ADDR_STATE_MISC, 8'h4c);
        waitCycles(3);
        check("reg four held", railOn[RAIL_L4], 1);
        setPins.buckBEnablePin = 0;
        waitCycles(4);
        check("buck b dropped", railOn[RAIL_BB], 0);
        check("internal rail", railOn[2], 1);
        waitCycles(190);
        check("rails before sleep", railOn == 0, 0);
        waitCycles(5);
        check("rails in sleep", railOn, 0);
        access(0, ADDR_RAIL_STAT_HI, 0);
        check("state sleep", rd[7:5], 3'd5);
        check("no power", noPowerResetOut, 0);
        results();
    end
endmodule : supply_enable_powerdown_seq_test
bind seps_supply_seq seps_chk chk_u (.sys_clk, .rstn, .regReq, .regRdData,
    .regAck, .pins, .railInReg, .railOn, .powerGood, .noRtcOut,
    .slowClockOut, .crystalClockIn, .slowClockLogicSupply,
    .linregZeroVoltage);
`default_nettype wire
